// [design/mmp_mac_port.sv]
// mii transmit/receive port with collision handling and abort statistics
// Function
// R1: count frames aborted by transmit fifo underrun in a 32-bit counter
// R2: count every aborted transmit frame in a second 32-bit counter
// R3: counters clear only on reset, never saturate, wrap past maximum
// R4: transmit nibbles synchronous to transmit clock, low nibble of byte first
// R5: transmit clock is 2.5 MHz at 10 Mbps, 25 MHz at 100 Mbps
// R6: transmit enable rises with the first preamble nibble
// R7: phy supplies transmit clock in dte; device divides it in dce
// R8: phy raises carrier sense on medium activity in half duplex
// R9: on collision replace outgoing nibbles with jam pattern 55555555
// R10: after collision wait randomly and retry, at most 16 attempts
// R11: collision and carrier inputs are asynchronous, used only in half duplex
// R12: phy drives receive nibbles on a 2.5 or 25 MHz receive clock
// R13: phy raises data valid from preamble or delimiter depending on speed
// R14: drop receive nibbles when data valid low or, in dte, error high
// R15: receive error held low by the outside in dce mode
// R16: retry delay uses truncated binary exponential backoff in slot times
`timescale 1ns/10ps
module mmp_mac_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_mii_tx_clk,
  input  wire logic        i_mii_rx_clk,
  input  wire logic        i_dce_mode,
  input  wire logic        i_full_duplex,
  input  wire logic        i_speed_100,
  input  wire logic        i_mii_crs,
  input  wire logic        i_mii_col,
  input  wire logic [3:0]  i_mii_rxd,
  input  wire logic        i_mii_rx_dv,
  input  wire logic        i_mii_rx_er,
  input  wire logic        i_tx_req,
  input  wire logic [7:0]  i_tx_byte,
  input  wire logic        i_tx_byte_valid,
  input  wire logic        i_tx_byte_last,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  output logic             o_mii_tx_clk,
  output logic [3:0]       o_mii_txd,
  output logic             o_mii_tx_en,
  output logic             o_tx_byte_ready,
  output logic             o_tx_rewind,
  output logic             o_tx_done,
  output logic             o_tx_abort,
  output logic [3:0]       o_rx_nibble,
  output logic             o_rx_nibble_valid,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_ack
);
  // ---------------- system clock side ----------------
  logic [1:0]  mode_meta;
  logic [1:0]  mode_sync;
  logic [5:0]  div_cnt;
  logic [31:0] underrun_abort_count_bits;
  logic [31:0] all_abort_count_bits;
  logic        und_pulse;
  logic        all_pulse;

  wire        dce_s  = mode_sync[0];
  wire        fast_s = mode_sync[1];
  wire [5:0]  div_last = fast_s ? 6'(mmp_pkg::DIV_HALF_FAST - 1)
                                : 6'(mmp_pkg::DIV_HALF_SLOW - 1);
  wire        div_wrap = (div_cnt == div_last);
  wire        hit_und  = (i_reg_addr == mmp_pkg::ADDR_UNDERRUN_CNT);
  wire        hit_all  = (i_reg_addr == mmp_pkg::ADDR_ALL_ABORT_CNT);
  wire [31:0] rd_mux   = hit_und ? underrun_abort_count_bits :
                         hit_all ? all_abort_count_bits : mmp_pkg::RD_UNMAPPED;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_meta <= 2'b00;
      mode_sync <= 2'b00;
    end else begin
      mode_meta <= {i_speed_100, i_dce_mode};
      mode_sync <= mode_meta;
    end
  end

  // transmit clock made from the system reference clock in dce mode
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt      <= 6'h00;
      o_mii_tx_clk <= 1'b0;
    end else if (!dce_s) begin
      div_cnt      <= 6'h00; // [R7]
      o_mii_tx_clk <= 1'b0;
    end else begin
      div_cnt      <= div_wrap ? 6'h00 : div_cnt + 6'h01; // [R5]
      o_mii_tx_clk <= o_mii_tx_clk ^ div_wrap; // [R7]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      underrun_abort_count_bits <= mmp_pkg::CNT_RESET; // [R3]
      all_abort_count_bits      <= mmp_pkg::CNT_RESET; // [R3]
    end else begin
      if (und_pulse) underrun_abort_count_bits <= underrun_abort_count_bits + 32'h1; // [R1]
      if (all_pulse) all_abort_count_bits <= all_abort_count_bits + 32'h1; // [R2]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_ack   <= 1'b0;
      o_reg_rdata <= mmp_pkg::RD_UNMAPPED;
    end else begin
      o_reg_ack   <= i_reg_rd;
      o_reg_rdata <= i_reg_rd ? rd_mux : mmp_pkg::RD_UNMAPPED;
    end
  end

  mmp_evt_if u_und_if ();
  mmp_evt_if u_all_if ();

  mmp_evt_sync u_und_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .evt       (u_und_if.dst),
    .o_pulse   (und_pulse)
  );

  mmp_evt_sync u_all_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .evt       (u_all_if.dst),
    .o_pulse   (all_pulse)
  );

  mmp_rx_nibble u_rx (
    .i_mii_rx_clk      (i_mii_rx_clk),
    .i_rst             (i_rst),
    .i_dce_mode        (i_dce_mode),
    .i_mii_rxd         (i_mii_rxd),
    .i_mii_rx_dv       (i_mii_rx_dv),
    .i_mii_rx_er       (i_mii_rx_er),
    .o_rx_nibble       (o_rx_nibble),
    .o_rx_nibble_valid (o_rx_nibble_valid)
  );

  // ---------------- transmit clock side ----------------
  function automatic logic [9:0] backoff_mask(input logic [4:0] tries);
    logic [4:0]  k;
    logic [10:0] m;
    k = (tries > mmp_pkg::BACKOFF_CAP) ? mmp_pkg::BACKOFF_CAP : tries;
    m = (11'h001 << k) - 11'h001;
    return m[9:0];
  endfunction

  mmp_pkg::mmp_tx_state_t state;
  mmp_pkg::mmp_tx_state_t next_state;
  logic       trst_meta;
  logic       trst;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       ph;
  logic       next_ph;
  logic [7:0] byte_q;
  logic [7:0] next_byte_q;
  logic       last_q;
  logic       next_last_q;
  logic [4:0] attempts;
  logic [4:0] next_attempts;
  logic [9:0] slots;
  logic [9:0] next_slots;
  logic [15:0] lfsr;
  logic [3:0] next_txd;
  logic       next_tx_en;
  logic       next_ready;
  logic       next_rewind;
  logic       next_done;
  logic       next_abort;
  logic       next_und;
  logic       next_all;

  wire half   = !pin_sync[2];
  wire crs_s  = pin_sync[0];
  wire col_s  = pin_sync[1];
  wire on_air = (state == mmp_pkg::MMP_PRE) || (state == mmp_pkg::MMP_DATA);
  wire col_hit = half && col_s && on_air; // [R11]
  wire take   = o_tx_byte_ready && i_tx_byte_valid;
  wire starve = o_tx_byte_ready && !i_tx_byte_valid;
  wire [4:0] tries_next = attempts + 5'h01;

  always_ff @(posedge i_mii_tx_clk or posedge i_rst) begin
    if (i_rst) begin
      trst_meta <= 1'b1;
      trst      <= 1'b1;
    end else begin
      trst_meta <= 1'b0;
      trst      <= trst_meta;
    end
  end

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_ph       = ph;
    next_byte_q   = byte_q;
    next_last_q   = last_q;
    next_attempts = attempts;
    next_slots    = slots;
    next_txd      = o_mii_txd;
    next_tx_en    = o_mii_tx_en;
    next_ready    = 1'b0;
    next_rewind   = 1'b0;
    next_done     = 1'b0;
    next_abort    = 1'b0;
    next_und      = u_und_if.toggle;
    next_all      = u_all_if.toggle;
    if (col_hit) begin
      next_state = mmp_pkg::MMP_JAM; // [R9]
      next_cnt   = 7'h00;
      next_txd   = mmp_pkg::NIB_JAM; // [R9]
    end else if (starve) begin
      next_state = mmp_pkg::MMP_IFG;
      next_cnt   = 7'h00;
      next_tx_en = 1'b0;
      next_txd   = mmp_pkg::NIB_IDLE;
      next_abort = 1'b1;
      next_und   = !u_und_if.toggle; // [R1]
      next_all   = !u_all_if.toggle; // [R2]
    end else begin
      unique case (state)
        mmp_pkg::MMP_IDLE: begin
          next_attempts = 5'h00;
          if (i_tx_req) next_state = mmp_pkg::MMP_DEFER;
        end
        mmp_pkg::MMP_DEFER: begin
          if (!(half && crs_s)) begin // [R11]
            next_state = mmp_pkg::MMP_PRE;
            next_cnt   = 7'h00;
            next_txd   = mmp_pkg::NIB_PRE; // [R6]
            next_tx_en = 1'b1; // [R6]
          end
        end
        mmp_pkg::MMP_PRE: begin
          if (cnt == mmp_pkg::PRE_LAST_AT) begin
            next_state  = mmp_pkg::MMP_DATA;
            next_ph     = 1'b0;
            next_byte_q = i_tx_byte;
            next_last_q = i_tx_byte_last;
            next_txd    = i_tx_byte[3:0]; // [R4]
          end else begin
            next_cnt   = cnt + 7'h01;
            next_ready = (cnt == mmp_pkg::PRE_SFD_AT);
            next_txd   = (cnt == mmp_pkg::PRE_SFD_AT) ? mmp_pkg::NIB_SFD : mmp_pkg::NIB_PRE;
          end
        end
        mmp_pkg::MMP_DATA: begin
          if (!ph) begin
            next_ph    = 1'b1;
            next_txd   = byte_q[7:4]; // [R4]
            next_ready = !last_q;
          end else if (last_q) begin
            next_state = mmp_pkg::MMP_IFG;
            next_cnt   = 7'h00;
            next_tx_en = 1'b0;
            next_txd   = mmp_pkg::NIB_IDLE;
            next_done  = 1'b1;
          end else if (take) begin
            next_ph     = 1'b0;
            next_byte_q = i_tx_byte;
            next_last_q = i_tx_byte_last;
            next_txd    = i_tx_byte[3:0]; // [R4]
          end
        end
        mmp_pkg::MMP_JAM: begin
          if (cnt == mmp_pkg::JAM_LAST_AT) begin
            next_tx_en    = 1'b0;
            next_txd      = mmp_pkg::NIB_IDLE;
            next_cnt      = 7'h00;
            next_attempts = tries_next;
            if (attempts == mmp_pkg::LAST_ATTEMPT) begin
              next_state = mmp_pkg::MMP_IFG; // [R10]
              next_abort = 1'b1;
              next_all   = !u_all_if.toggle; // [R2]
            end else begin
              next_state  = mmp_pkg::MMP_BACKOFF;
              next_rewind = 1'b1; // [R10]
              next_slots  = lfsr[9:0] & backoff_mask(tries_next); // [R16]
            end
          end else begin
            next_cnt = cnt + 7'h01;
            next_txd = mmp_pkg::NIB_JAM; // [R9]
          end
        end
        mmp_pkg::MMP_BACKOFF: begin
          if (slots == 10'h000) begin
            next_state = mmp_pkg::MMP_DEFER;
          end else begin
            next_cnt = cnt + 7'h01; // [R16]
            if (cnt == mmp_pkg::SLOT_LAST_AT) next_slots = slots - 10'h001;
          end
        end
        mmp_pkg::MMP_IFG: begin
          next_cnt = cnt + 7'h01;
          if (cnt == mmp_pkg::IFG_LAST_AT) next_state = mmp_pkg::MMP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mii_tx_clk or posedge trst) begin
    if (trst) begin
      pin_meta <= 3'b000;
      pin_sync <= 3'b000;
      lfsr     <= mmp_pkg::LFSR_SEED;
    end else begin
      pin_meta <= {i_full_duplex, i_mii_col, i_mii_crs}; // [R11]
      pin_sync <= pin_meta;
      lfsr     <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge i_mii_tx_clk or posedge trst) begin
    if (trst) begin
      state           <= mmp_pkg::MMP_IDLE;
      cnt             <= 7'h00;
      ph              <= 1'b0;
      byte_q          <= 8'h00;
      last_q          <= 1'b0;
      attempts        <= 5'h00;
      slots           <= 10'h000;
      o_mii_txd       <= mmp_pkg::NIB_IDLE;
      o_mii_tx_en     <= 1'b0;
      o_tx_byte_ready <= 1'b0;
      o_tx_rewind     <= 1'b0;
      o_tx_done       <= 1'b0;
      o_tx_abort      <= 1'b0;
      u_und_if.toggle <= 1'b0;
      u_all_if.toggle <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      ph              <= next_ph;
      byte_q          <= next_byte_q;
      last_q          <= next_last_q;
      attempts        <= next_attempts;
      slots           <= next_slots;
      o_mii_txd       <= next_txd;
      o_mii_tx_en     <= next_tx_en;
      o_tx_byte_ready <= next_ready;
      o_tx_rewind     <= next_rewind;
      o_tx_done       <= next_done;
      o_tx_abort      <= next_abort;
      u_und_if.toggle <= next_und;
      u_all_if.toggle <= next_all;
    end
  end

  // ---------------- checks ----------------
  a_txen_with_pre: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R6]
    $rose(o_mii_tx_en) |-> (o_mii_txd == 4'h5) && (state == mmp_pkg::MMP_PRE))
    else $error("transmit enable rose without a preamble nibble");
  a_jam_pattern: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R9]
    $rose(state == mmp_pkg::MMP_JAM) |-> (o_mii_txd == 4'h5 && o_mii_tx_en) [*8])
    else $error("jam is not eight nibbles of five");
  a_col_to_jam: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R9]
    col_hit |=> state == mmp_pkg::MMP_JAM) else $error("collision did not start jam");
  a_fd_no_jam: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R11]
    (!half && on_air) |=> state != mmp_pkg::MMP_JAM) else $error("jam in full duplex");
  a_attempt_limit: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R10]
    (state == mmp_pkg::MMP_BACKOFF) |-> (attempts < 5'd16 && attempts != 5'd0))
    else $error("retry beyond sixteen attempts");
  a_lsb_first: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R4]
    (take && !col_hit) |=> (o_mii_txd == $past(i_tx_byte[3:0]))
    ##1 (o_mii_txd == ($past(col_hit) ? mmp_pkg::NIB_JAM : byte_q[7:4])))
    else $error("byte not sent low nibble first");
  a_underrun_stop: assert property (@(posedge i_mii_tx_clk) disable iff (trst) // [R1]
    (starve && !col_hit) |=> !o_mii_tx_en && o_tx_abort) else $error("underrun not aborted");
  a_und_count: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
    und_pulse |=> underrun_abort_count_bits == $past(underrun_abort_count_bits) + 32'h1)
    else $error("underrun counter did not step");
  a_all_count: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
    all_pulse |=> all_abort_count_bits == $past(all_abort_count_bits) + 32'h1)
    else $error("abort counter did not step");
  a_count_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R3]
    !all_pulse |=> $stable(all_abort_count_bits)) else $error("abort counter moved alone");
  a_dte_no_clock: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R7]
    !dce_s |=> !o_mii_tx_clk) else $error("clock driven out in dte mode");
endmodule

// [inc/mmp_pkg.sv]
// constants and types shared by the mii mac port files
package mmp_pkg;
  localparam int SYS_CLK_HZ    = 200_000_000;
  localparam int TX_HZ_FAST    = 25_000_000;
  localparam int TX_HZ_SLOW    = 2_500_000;
  localparam int DIV_HALF_FAST = SYS_CLK_HZ / (2 * TX_HZ_FAST);
  localparam int DIV_HALF_SLOW = SYS_CLK_HZ / (2 * TX_HZ_SLOW);

  localparam logic [15:0] ADDR_UNDERRUN_CNT = 16'h0334;
  localparam logic [15:0] ADDR_ALL_ABORT_CNT = 16'h0338;
  localparam logic [31:0] CNT_RESET         = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED       = 32'h0000_0000;

  localparam logic [3:0] NIB_PRE  = 4'h5;
  localparam logic [3:0] NIB_SFD  = 4'hD;
  localparam logic [3:0] NIB_JAM  = 4'h5;
  localparam logic [3:0] NIB_IDLE = 4'h0;

  localparam logic [6:0] PRE_SFD_AT  = 7'h0E;
  localparam logic [6:0] PRE_LAST_AT = 7'h0F;
  localparam logic [6:0] JAM_LAST_AT = 7'h07;
  localparam logic [6:0] IFG_LAST_AT = 7'h17;
  localparam logic [6:0] SLOT_LAST_AT = 7'h7F;
  localparam logic [4:0] LAST_ATTEMPT = 5'h0F;
  localparam logic [4:0] BACKOFF_CAP  = 5'h0A;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;

  typedef enum logic [2:0] {
    MMP_IDLE, MMP_DEFER, MMP_PRE, MMP_DATA, MMP_JAM, MMP_BACKOFF, MMP_IFG
  } mmp_tx_state_t;
endpackage

// [inc/mmp_evt_if.sv]
// toggle carrier for one event crossing from the transmit clock to the system clock
`timescale 1ns/10ps
interface mmp_evt_if;
  logic toggle;
  modport src (output toggle);
  modport dst (input toggle);
endinterface

// [design/mmp_evt_sync.sv]
// toggle synchroniser turning a far-domain toggle into a one-cycle pulse
`timescale 1ns/10ps
module mmp_evt_sync (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst,
  mmp_evt_if.dst     evt,
  output logic       o_pulse
);
  logic meta;
  logic sync;
  logic prev;
  wire  edge_seen = sync ^ prev;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta    <= 1'b0;
      sync    <= 1'b0;
      prev    <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      meta    <= evt.toggle;
      sync    <= meta;
      prev    <= sync;
      o_pulse <= edge_seen;
    end
  end

  a_pulse_follows_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
    $changed(sync) |=> o_pulse) else $error("toggle change not turned into a pulse");
endmodule

// [design/mmp_rx_nibble.sv]
// receive nibble filter on the phy receive clock
`timescale 1ns/10ps
module mmp_rx_nibble (
  input  wire logic       i_mii_rx_clk,
  input  wire logic       i_rst,
  input  wire logic       i_dce_mode,
  input  wire logic [3:0] i_mii_rxd,
  input  wire logic       i_mii_rx_dv,
  input  wire logic       i_mii_rx_er,
  output logic [3:0]      o_rx_nibble,
  output logic            o_rx_nibble_valid
);
  logic rst_meta;
  logic rst_sync;
  logic dce_meta;
  logic dce_sync;
  // error input only counts in dte mode; in dce it is tied low outside
  wire  keep = i_mii_rx_dv && !(i_mii_rx_er && !dce_sync);

  always_ff @(posedge i_mii_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_sync <= rst_meta;
    end
  end

  always_ff @(posedge i_mii_rx_clk or posedge rst_sync) begin
    if (rst_sync) begin
      dce_meta          <= 1'b0;
      dce_sync          <= 1'b0;
      o_rx_nibble       <= 4'h0;
      o_rx_nibble_valid <= 1'b0;
    end else begin
      dce_meta          <= i_dce_mode;
      dce_sync          <= dce_meta;
      o_rx_nibble       <= i_mii_rxd;
      o_rx_nibble_valid <= keep; // [R14]
    end
  end

  a_rx_drop_idle: assert property (@(posedge i_mii_rx_clk) disable iff (rst_sync) // [R14]
    !i_mii_rx_dv |=> !o_rx_nibble_valid) else $error("nibble kept without data valid");
  a_rx_drop_err: assert property (@(posedge i_mii_rx_clk) disable iff (rst_sync) // [R14]
    (i_mii_rx_er && !dce_sync) |=> !o_rx_nibble_valid) else $error("errored nibble kept");
endmodule

// [sim/mmp_phy_model.sv]
// behavioural mii phy standing at the far side of the mac port
`timescale 1ns/10ps
module mmp_phy_model (
  input  wire logic  i_mii_tx_en,
  input  wire logic  i_col_arm,
  input  wire logic  i_rx_run,
  output logic       o_mii_tx_clk,
  output logic       o_mii_rx_clk,
  output logic [3:0] o_mii_rxd,
  output logic       o_mii_rx_dv,
  output logic       o_mii_rx_er,
  output logic       o_mii_crs,
  output logic       o_mii_col
);
  logic       rx_on;
  logic [3:0] col_cnt;

  // transmit clock runs free, phase unrelated to the system clock
  initial begin
    o_mii_tx_clk = 1'b0;
    #37;
    forever #80 o_mii_tx_clk = ~o_mii_tx_clk;
  end

  // receive clock only runs while i_rx_run is high (reset and a few transmit clocks after) and within frames
  initial begin
    o_mii_rx_clk = 1'b0;
    o_mii_rxd = 4'hA;
    o_mii_rx_dv = 1'b0;
    o_mii_rx_er = 1'b0;
    rx_on = 1'b0;
    forever #80 if (rx_on || i_rx_run || o_mii_rx_clk) o_mii_rx_clk = ~o_mii_rx_clk;
  end

  assign o_mii_crs = i_mii_tx_en | o_mii_rx_dv;

  // one collision per arming, a few nibbles into the attempt
  always @(posedge o_mii_tx_clk) begin
    if (!i_col_arm) col_cnt <= 4'h0;
    else if (col_cnt < 4'hA && (i_mii_tx_en || col_cnt != 4'h0)) col_cnt <= col_cnt + 4'h1;
    o_mii_col <= i_col_arm && col_cnt >= 4'h6 && col_cnt < 4'hA;
  end

  task automatic rx_nib(input logic [3:0] nib, input logic dv, input logic er);
    rx_on = 1'b1;
    @(negedge o_mii_rx_clk);
    o_mii_rxd = nib;
    o_mii_rx_dv = dv;
    o_mii_rx_er = er;
  endtask

  // released lines show the inverse of the last nibble
  task automatic rx_end();
    @(negedge o_mii_rx_clk);
    o_mii_rxd = ~o_mii_rxd;
    o_mii_rx_dv = 1'b0;
    o_mii_rx_er = 1'b0;
    @(negedge o_mii_rx_clk);
    rx_on = 1'b0;
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the mii mac port
`timescale 1ns/10ps
module tb;
  logic        sys_clk, rst, full_dup, col_arm, rx_run, tx_req, tx_valid, tx_last, reg_rd;
  logic        txc, rxc, crs, col, rx_dv, rx_er, tx_en, tx_clk_out;
  logic        ready, rewind, done, abort, rx_valid, ack, tx_chk, dce, speed;
  logic [3:0]  rxd, txd, rx_nib;
  logic [7:0]  tx_byte;
  logic [15:0] reg_addr;
  logic [31:0] rdata;
  logic [31:0] lfsr = 32'h0000_0020;
  logic [7:0]  bytes [8];
  logic [3:0]  q_tx [$];
  logic [3:0]  q_rx [$];
  logic [31:0] q_reg [$];
  int          idx, nbytes, nvalid, i;
  int          num_errors = 0;
  int          checks = 0;

  mmp_mac_port u_mmp_mac_port (.i_sys_clk(sys_clk), .i_rst(rst), .i_mii_tx_clk(txc),
    .i_mii_rx_clk(rxc), .i_dce_mode(dce), .i_full_duplex(full_dup), .i_speed_100(speed),
    .i_mii_crs(crs), .i_mii_col(col), .i_mii_rxd(rxd), .i_mii_rx_dv(rx_dv),
    .i_mii_rx_er(rx_er), .i_tx_req(tx_req), .i_tx_byte(tx_byte), .i_tx_byte_valid(tx_valid),
    .i_tx_byte_last(tx_last), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .o_mii_tx_clk(tx_clk_out), .o_mii_txd(txd), .o_mii_tx_en(tx_en), .o_tx_byte_ready(ready),
    .o_tx_rewind(rewind), .o_tx_done(done), .o_tx_abort(abort), .o_rx_nibble(rx_nib),
    .o_rx_nibble_valid(rx_valid), .o_reg_rdata(rdata), .o_reg_ack(ack));

  mmp_phy_model u_mmp_phy_model (.i_mii_tx_en(tx_en), .i_col_arm(col_arm), .i_rx_run(rx_run),
    .o_mii_tx_clk(txc), .o_mii_rx_clk(rxc), .o_mii_rxd(rxd), .o_mii_rx_dv(rx_dv),
    .o_mii_rx_er(rx_er), .o_mii_crs(crs), .o_mii_col(col));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    lfsr = lfsr ^ (lfsr << 13);
    lfsr = lfsr ^ (lfsr >> 17);
    lfsr = lfsr ^ (lfsr << 5);
    return lfsr;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic give_up(input logic hit);
    if (hit) begin
      check("bounded wait", 32'h0, 32'h1);
      stop_test();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    q_reg.push_back(e);
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
  endtask

  // measures one high phase of the divided transmit clock in system clocks
  task automatic half_period(input int exp);
    int n;
    for (n = 0; n < 100 && tx_clk_out !== 1'b0; n++) @(posedge sys_clk);
    for (n = 0; n < 100 && tx_clk_out !== 1'b1; n++) @(posedge sys_clk);
    give_up(n == 100);
    for (n = 0; n < 100 && tx_clk_out !== 1'b0; n++) @(posedge sys_clk);
    give_up(n == 100);
    check("tx clock half", 32'(n), 32'(exp));
  endtask

  task automatic push_frame();
    int k;
    for (k = 0; k < 15; k++) q_tx.push_back(mmp_pkg::NIB_PRE);
    q_tx.push_back(mmp_pkg::NIB_SFD);
    for (k = 0; k < nvalid; k++) begin
      q_tx.push_back(bytes[k][3:0]);
      q_tx.push_back(bytes[k][7:4]);
    end
  endtask

  // half-duplex collision frames are checked as jam until the source is rewound
  task automatic frame(input int n, input int nv, input logic coll, input logic exp_abort);
    int k;
    for (k = 0; k < 8; k++) bytes[k] = 8'(xs());
    nbytes = n;
    nvalid = nv;
    idx = 0;
    tx_chk = !(coll && !full_dup);
    col_arm = coll;
    if (tx_chk) push_frame();
    @(posedge txc);
    #1 tx_req = 1'b1;
    if (!tx_chk) begin
      for (k = 0; k < 400 && rewind !== 1'b1; k++) @(posedge txc);
      check("rewind", rewind, 32'h1);
      give_up(k == 400);
      for (k = 0; k < 40 && tx_en !== 1'b0; k++) @(posedge txc);
      give_up(k == 40);
      push_frame();
      tx_chk = 1'b1;
    end
    for (k = 0; k < 800 && done !== 1'b1 && abort !== 1'b1; k++) @(posedge txc);
    give_up(k == 800);
    check("abort", abort, 32'(exp_abort));
    #1 tx_req = 1'b0;
    col_arm = 1'b0;
    repeat (30) @(posedge txc);
  endtask

  // byte source: advance on taken bytes, restart on rewind
  always @(posedge txc) begin
    if (rewind === 1'b1) idx = 0;
    else if (ready === 1'b1 && tx_valid) idx = idx + 1;
    #1;
    tx_valid = idx < nvalid;
    tx_byte = bytes[idx & 7];
    tx_last = idx == nbytes - 1;
  end

  always @(posedge txc) if (tx_en === 1'b1) begin
    if (!tx_chk) check("jam nibble", 32'(txd), 32'(mmp_pkg::NIB_JAM));
    else if (q_tx.size() == 0) check("tx extra nibble", 32'h1, 32'h0);
    else check("txd", 32'(txd), 32'(q_tx.pop_front()));
  end

  always @(posedge rxc) if (rx_valid === 1'b1) begin
    if (q_rx.size() == 0) check("rx extra nibble", 32'h1, 32'h0);
    else check("rx nibble", 32'(rx_nib), 32'(q_rx.pop_front()));
  end

  always @(posedge sys_clk) if (ack === 1'b1) begin
    if (q_reg.size() == 0) check("reg extra ack", 32'h1, 32'h0);
    else check("reg rdata", rdata, q_reg.pop_front());
  end

  initial begin
    #400_000;
    give_up(1'b1);
  end

  initial begin
    logic [31:0] r;
    logic        rer;
    rst = 1'b1;
    dce = 1'b0;
    speed = 1'b1;
    full_dup = 1'b0;
    col_arm = 1'b0;
    rx_run = 1'b1;
    tx_req = 1'b0;
    tx_byte = 8'h00;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    tx_chk = 1'b1;
    nbytes = 0;
    nvalid = 0;
    idx = 0;
    // reset spans the slow link clocks so their synchronisers see edges
    repeat (10) @(posedge txc);
    #1 rst = 1'b0;
    repeat (4) @(posedge txc);
    rx_run = 1'b0;
    check("tx clock out", 32'(tx_clk_out), 32'h0);
    rd(mmp_pkg::ADDR_UNDERRUN_CNT, mmp_pkg::CNT_RESET);
    rd(mmp_pkg::ADDR_ALL_ABORT_CNT, mmp_pkg::CNT_RESET);
    rd(16'h0330, mmp_pkg::RD_UNMAPPED);
    frame(4, 4, 1'b0, 1'b0);
    frame(3, 1, 1'b0, 1'b1);
    frame(2, 0, 1'b0, 1'b1);
    rd(mmp_pkg::ADDR_UNDERRUN_CNT, 32'h0000_0002);
    rd(mmp_pkg::ADDR_ALL_ABORT_CNT, 32'h0000_0002);
    frame(2, 2, 1'b1, 1'b0);
    full_dup = 1'b1;
    repeat (4) @(posedge txc);
    frame(3, 3, 1'b1, 1'b0);
    rd(mmp_pkg::ADDR_ALL_ABORT_CNT, 32'h0000_0002);
    rd(mmp_pkg::ADDR_UNDERRUN_CNT, 32'h0000_0002);
    q_rx.push_back(mmp_pkg::NIB_PRE);
    u_mmp_phy_model.rx_nib(mmp_pkg::NIB_PRE, 1'b1, 1'b0);
    for (i = 0; i < 24; i++) begin
      r = xs();
      if (i == 16) dce = 1'b1;
      rer = r[5] & r[6] & !dce;
      if (r[4] && !rer) q_rx.push_back(r[3:0]);
      u_mmp_phy_model.rx_nib(r[3:0], r[4], rer);
    end
    u_mmp_phy_model.rx_end();
    half_period(mmp_pkg::DIV_HALF_FAST);
    #1 speed = 1'b0;
    repeat (100) @(posedge sys_clk);
    half_period(mmp_pkg::DIV_HALF_SLOW);
    repeat (10) @(posedge sys_clk);
    check("tx nibbles left", q_tx.size(), 32'h0);
    check("rx nibbles left", q_rx.size(), 32'h0);
    check("reads left", q_reg.size(), 32'h0);
    stop_test();
  end
endmodule
